// ---- hw/plc_pkg.sv ----
// Purpose: Shared constants for the PLL lock interrupt and low-power control block
// Assumes: One bus clock, asynchronous active-high reset
// Notes: Reset values of the control bits live here
package plc_pkg;
	// Reset values of software-visible control bits
	localparam logic RST_PLL_POWER_ON = 1'h1;
	localparam logic RST_BASE_CLOCK_SELECT = 1'h0;
	localparam logic RST_PLL_IRQ_ENABLE = 1'h0;
	localparam logic RST_AUTO_BW = 1'h0;
	localparam logic RST_EVENT_FLAG = 1'h0;
	// Reset values of status and generator outputs
	localparam logic RST_LOCK_IND = 1'h0;
	localparam logic RST_IRQ = 1'h0;
	localparam logic RST_PLL_RUN = 1'h0;
	localparam logic RST_OSC_RUN = 1'h1;
	localparam logic RST_OUTPUTS_EN = 1'h1;
	localparam logic RST_MODE_IND = 1'h0;
	// Synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 3;
	// Low-power state encoding, one bit apart from run each way
	typedef enum logic [1:0] {
		PLC_RUN = 2'h0,
		PLC_WAIT = 2'h1,
		PLC_STOP = 2'h2
	} plc_pwr_t;
endpackage

// ---- hw/plc_sync.sv ----
// Purpose: Three-stage synchroniser with agreement filter for one pin input
// Assumes: Input is asynchronous to clk
// Notes: A change counts once stages two and three agree
`timescale 1ns/1ps
module plc_sync #(
	parameter logic RST_VAL = 1'h0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Raw pin and filtered level
	input wire logic pin_in,
	output logic level_out
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic level_ff;
	wire logic agree = (s2_ff == s3_ff);

	// Shift chain; first stage feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_ff <= RST_VAL;
			s2_ff <= RST_VAL;
			s3_ff <= RST_VAL;
		end else begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Filtered level follows only on agreement
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			level_ff <= RST_VAL;
		end else if (agree) begin
			level_ff <= s3_ff;
		end
	end

	assign level_out = level_ff;
endmodule // plc_sync

// ---- hw/plc_ctl.sv ----
// Purpose: PLL lock-change event flag, interrupt gating, clock select and low-power control
// Assumes: Lock level arrives from the analog loop on a pin; bus strobes are on clk
// Notes: Control bits are plain ports; writes are single-cycle strobes
`timescale 1ns/1ps
module plc_ctl (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control register write strobe and data
	input wire logic ctl_wr,
	input wire logic wr_pll_irq_enable,
	input wire logic wr_base_clock_select,
	input wire logic wr_pll_power_on,
	// Control register read strobe
	input wire logic ctl_rd,
	// Bandwidth control write
	input wire logic bw_wr,
	input wire logic wr_auto_bw,
	// Analog loop lock level, asynchronous
	input wire logic vco_locked_pin,
	// System mode inputs
	input wire logic wait_req,
	input wire logic stop_req,
	input wire logic wake,
	input wire logic osc_in_stop_enable,
	input wire logic break_active,
	input wire logic break_flag_clear_enable,
	// Readback
	output logic pll_irq_enable,
	output logic base_clock_select,
	output logic pll_power_on,
	output logic auto_bw,
	output logic lock_ind,
	output logic pll_event_flag,
	// Clock generator controls
	output logic clockgen_irq,
	output logic pll_run,
	output logic osc_run,
	output logic clk_outputs_en,
	output logic in_wait,
	output logic in_stop
);
	logic ie_ff;
	logic bcs_ff;
	logic pon_ff;
	logic auto_ff;
	logic lock_ff;
	logic flag_ff;
	logic irq_ff;
	logic pll_run_ff;
	logic osc_run_ff;
	logic outen_ff;
	logic wait_ff;
	logic stop_ff;
	logic lock_sync;
	plc_pkg::plc_pwr_t pwr_ff;
	plc_pkg::plc_pwr_t nxt_pwr;
	logic nxt_bcs;
	logic nxt_pon;
	logic nxt_flag;
	logic nxt_lock;

	// Lock pin synchroniser
	plc_sync #(.RST_VAL(plc_pkg::RST_LOCK_IND)) u_lock_sync (
		.clk(clk),
		.rst(rst),
		.pin_in(vco_locked_pin),
		.level_out(lock_sync)
	);

	// Lock indicator is meaningful only in auto mode and with PLL running
	assign nxt_lock = auto_ff & pll_run_ff & lock_sync;
	// Either edge of the settled level counts, only in auto mode
	wire logic lock_edge = (nxt_lock != lock_ff);
	wire logic lock_event = lock_edge & auto_ff;
	wire logic stopping = (pwr_ff == plc_pkg::PLC_STOP);
	// Stop is entered only from run; a stop request in wait is ignored
	wire logic entering_stop = stop_req & (pwr_ff == plc_pkg::PLC_RUN);
	// Read clears flag outside break, or in break when clearing allowed
	wire logic rd_clear = ctl_rd & (~break_active | break_flag_clear_enable);

	// Event flag: set wins over clear; manual mode forces zero
	always_comb begin
		nxt_flag = flag_ff;
		if (rd_clear) begin
			nxt_flag = 1'h0;
		end
		if (lock_event) begin
			nxt_flag = 1'h1;
		end
		if (!auto_ff) begin
			nxt_flag = 1'h0;
		end
	end

	// Clock select and power interlock; stop forces select clear
	always_comb begin
		nxt_bcs = bcs_ff;
		nxt_pon = pon_ff;
		if (ctl_wr) begin
			// Power may drop only while select is clear
			if (!(!wr_pll_power_on && bcs_ff)) begin
				nxt_pon = wr_pll_power_on;
			end
			// Select may be set without lock, never with PLL off now or next
			if (!(wr_base_clock_select && !(pon_ff && nxt_pon))) begin
				nxt_bcs = wr_base_clock_select;
			end
		end
		// Stop entry hands the output back to the oscillator
		if (entering_stop) begin
			nxt_bcs = 1'h0;
		end
	end

	// Low-power sequencing; wait alters nothing in the generator
	always_comb begin
		nxt_pwr = pwr_ff;
		case (pwr_ff)
			plc_pkg::PLC_RUN: begin
				if (stop_req) begin
					nxt_pwr = plc_pkg::PLC_STOP;
				end else if (wait_req) begin
					nxt_pwr = plc_pkg::PLC_WAIT;
				end
			end
			plc_pkg::PLC_WAIT: begin
				if (wake) begin
					nxt_pwr = plc_pkg::PLC_RUN;
				end
			end
			plc_pkg::PLC_STOP: begin
				if (wake) begin
					nxt_pwr = plc_pkg::PLC_RUN;
				end
			end
			default: begin
				nxt_pwr = plc_pkg::PLC_RUN;
			end
		endcase
	end

	// Generator enables by mode
	wire logic nxt_pll_run = pon_ff & ~stopping;
	wire logic nxt_osc_run = ~stopping | osc_in_stop_enable;
	wire logic nxt_outen = ~stopping | osc_in_stop_enable;
	// Irq follows the output enable so it is held low in a full stop
	wire logic nxt_irq = flag_ff & ie_ff & auto_ff & nxt_outen;

	// Software control bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ie_ff <= plc_pkg::RST_PLL_IRQ_ENABLE;
			auto_ff <= plc_pkg::RST_AUTO_BW;
			bcs_ff <= plc_pkg::RST_BASE_CLOCK_SELECT;
			pon_ff <= plc_pkg::RST_PLL_POWER_ON;
		end else begin
			if (ctl_wr) begin
				ie_ff <= wr_pll_irq_enable;
			end
			if (bw_wr) begin
				auto_ff <= wr_auto_bw;
			end
			bcs_ff <= nxt_bcs;
			pon_ff <= nxt_pon;
		end
	end

	// Status, mode and output registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lock_ff <= plc_pkg::RST_LOCK_IND;
			flag_ff <= plc_pkg::RST_EVENT_FLAG;
			pwr_ff <= plc_pkg::PLC_RUN;
			irq_ff <= plc_pkg::RST_IRQ;
			// PLL run follows power one edge after release
			pll_run_ff <= plc_pkg::RST_PLL_RUN;
			osc_run_ff <= plc_pkg::RST_OSC_RUN;
			outen_ff <= plc_pkg::RST_OUTPUTS_EN;
			wait_ff <= plc_pkg::RST_MODE_IND;
			stop_ff <= plc_pkg::RST_MODE_IND;
		end else begin
			lock_ff <= nxt_lock;
			flag_ff <= nxt_flag;
			pwr_ff <= nxt_pwr;
			irq_ff <= nxt_irq;
			pll_run_ff <= nxt_pll_run;
			osc_run_ff <= nxt_osc_run;
			outen_ff <= nxt_outen;
			wait_ff <= (nxt_pwr == plc_pkg::PLC_WAIT);
			stop_ff <= (nxt_pwr == plc_pkg::PLC_STOP);
		end
	end

	// Outputs straight from flip-flops
	assign pll_irq_enable = ie_ff;
	assign base_clock_select = bcs_ff;
	assign pll_power_on = pon_ff;
	assign auto_bw = auto_ff;
	assign lock_ind = lock_ff;
	assign pll_event_flag = flag_ff;
	assign clockgen_irq = irq_ff;
	assign pll_run = pll_run_ff;
	assign osc_run = osc_run_ff;
	assign clk_outputs_en = outen_ff;
	assign in_wait = wait_ff;
	assign in_stop = stop_ff;
endmodule // plc_ctl

// ---- test/plc_ctl_chk.sv ----
// Purpose: Assertions on lock events, irq gating and stop behaviour
// Assumes: Sees only plc_ctl ports; one clock
// Notes: Bound into every plc_ctl
`timescale 1ns/1ps
module plc_ctl_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Inputs
	input wire logic ctl_rd,
	input wire logic bw_wr,
	input wire logic osc_in_stop_enable,
	input wire logic break_active,
	input wire logic break_flag_clear_enable,
	// Outputs
	input wire logic pll_irq_enable,
	input wire logic base_clock_select,
	input wire logic pll_power_on,
	input wire logic auto_bw,
	input wire logic lock_ind,
	input wire logic pll_event_flag,
	input wire logic clockgen_irq,
	input wire logic pll_run,
	input wire logic osc_run,
	input wire logic clk_outputs_en,
	input wire logic in_stop
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// Event flag and irq
	flag_set_a: assert property (auto_bw && $changed(lock_ind) |-> pll_event_flag)
		else $error("lock change missed");
	manual_zero_a: assert property (!auto_bw ##1 !auto_bw |-> !pll_event_flag && !lock_ind)
		else $error("manual mode flag set");
	irq_gate_a: assert property (!pll_irq_enable ##1 !pll_irq_enable |-> !clockgen_irq)
		else $error("irq while disabled");
	read_clr_a: assert property (ctl_rd && (!break_active || break_flag_clear_enable)
		|=> !pll_event_flag || $changed(lock_ind))
		else $error("read left flag set");
	break_keep_a: assert property (break_active && !break_flag_clear_enable && pll_event_flag
		&& auto_bw && !bw_wr |=> pll_event_flag)
		else $error("flag lost in break");
	// Clock select and stop
	power_interlock_a: assert property (base_clock_select |-> pll_power_on)
		else $error("select without power");
	stop_select_a: assert property ($rose(in_stop) |-> !base_clock_select)
		else $error("select kept in stop");
	stop_off_a: assert property (in_stop ##1 in_stop && !osc_in_stop_enable
		|-> !osc_run && !clk_outputs_en && !clockgen_irq && !pll_run)
		else $error("outputs live in stop");
	stop_osc_on_a: assert property (in_stop ##1 in_stop && osc_in_stop_enable
		|-> osc_run && !pll_run)
		else $error("osc lost in stop");
	// Main scenarios
	cover property ($rose(clockgen_irq));
	cover property ($rose(in_stop));
	cover property (break_active && ctl_rd);
endmodule // plc_ctl_chk
bind plc_ctl plc_ctl_chk u_chk (.*);

// ---- test/plc_cpu_mdl.sv ----
// Purpose: Processor side servicing the clock generator irq
// Assumes: Service only while isr_en is high
// Notes: One status read per request
`timescale 1ns/1ps
module plc_cpu_mdl (
	// Clock
	input wire logic clk,
	// Service enable and request
	input wire logic isr_en,
	input wire logic clockgen_irq,
	// Status read strobe
	output logic mdl_rd
);
	logic req_ff = 1'h0;
	logic served_ff = 1'h0;
	// Note a request on the rising edge, once per irq assertion
	always @(posedge clk) begin
		req_ff <= isr_en && clockgen_irq && !served_ff && !req_ff;
		served_ff <= clockgen_irq && (served_ff || req_ff);
	end
	// Issue the single status read off the sampling edge
	always @(negedge clk) begin
		mdl_rd <= req_ff;
	end
endmodule // plc_cpu_mdl

// ---- test/plc_ctl_tb_top.sv ----
// Purpose: Directed bench for plc_ctl
// Assumes: Inputs change on falling edge
// Notes: Irq service reads come from plc_cpu_mdl
`timescale 1ns/1ps
module plc_ctl_tb_top;
	// Stimulus and outputs
	logic clk = 0, rst = 1, ctl_wr = 0, wr_pll_irq_enable = 0, wr_base_clock_select = 0;
	logic wr_pll_power_on = 0, bw_wr = 0, wr_auto_bw = 0, vco_locked_pin = 0, wait_req = 0;
	logic stop_req = 0, wake = 0, osc_in_stop_enable = 0, break_active = 0, tb_rd = 0;
	logic break_flag_clear_enable = 0, isr_en = 0, mdl_rd, pll_irq_enable, base_clock_select;
	logic pll_power_on, auto_bw, lock_ind, pll_event_flag, clockgen_irq, pll_run, osc_run;
	logic clk_outputs_en, in_wait, in_stop;
	wire logic ctl_rd;
	int n_fail = 0, checks_done = 0;
	assign ctl_rd = tb_rd | mdl_rd;
	plc_ctl DUT (.*);
	plc_cpu_mdl u_cpu (.clk(clk), .isr_en(isr_en), .clockgen_irq(clockgen_irq), .mdl_rd(mdl_rd));
	// 200 MHz clock
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'h1;
		cyc(1);
		s = 1'h0;
		cyc(1);
	endtask
	task automatic wr_ctl(input logic [2:0] v);
		{wr_pll_irq_enable, wr_base_clock_select, wr_pll_power_on} = v;
		pulse(ctl_wr);
	endtask
	task automatic chk(input logic seen, input logic exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (2000) @(posedge clk);
		n_fail++;
		give_verdict;
	end
	// Main sequence
	initial begin
		cyc(10);
		rst = 0;
		cyc(2);
		chk(pll_event_flag, plc_pkg::RST_EVENT_FLAG);
		wr_ctl(3'h0);
		wr_ctl(3'h2);
		chk(base_clock_select, 1'h0);
		wr_ctl(3'h1);
		wr_ctl(3'h7);
		chk(base_clock_select, 1'h1);
		wr_ctl(3'h6);
		chk(pll_power_on, 1'h1);
		vco_locked_pin = 1;
		cyc(8);
		chk(lock_ind | pll_event_flag, 1'h0);
		wr_auto_bw = 1;
		pulse(bw_wr);
		chk(auto_bw, 1'h1);
		cyc(8);
		chk(pll_event_flag & lock_ind & clockgen_irq, 1'h1);
		break_active = 1;
		pulse(tb_rd);
		chk(pll_event_flag, 1'h1);
		break_flag_clear_enable = 1;
		pulse(tb_rd);
		break_active = 0;
		cyc(2);
		chk(pll_event_flag | clockgen_irq, 1'h0);
		wr_ctl(3'h3);
		vco_locked_pin = 0;
		cyc(8);
		chk(pll_event_flag & !clockgen_irq, 1'h1);
		wr_ctl(3'h7);
		chk(pll_irq_enable, 1'h1);
		isr_en = 1;
		cyc(6);
		chk(pll_event_flag | lock_ind, 1'h0);
		isr_en = 0;
		pulse(wait_req);
		chk(in_wait & base_clock_select & pll_run & osc_run, 1'h1);
		pulse(wake);
		cyc(1);
		pulse(stop_req);
		cyc(1);
		chk(base_clock_select | pll_run | osc_run | clk_outputs_en, 1'h0);
		pulse(wake);
		cyc(1);
		chk(base_clock_select | in_stop, 1'h0);
		osc_in_stop_enable = 1;
		pulse(stop_req);
		cyc(1);
		chk(osc_run & !pll_run, 1'h1);
		pulse(wake);
		vco_locked_pin = 1;
		cyc(8);
		chk(pll_event_flag, 1'h1);
		rst = 1;
		cyc(2);
		rst = 0;
		cyc(2);
		chk(pll_event_flag, plc_pkg::RST_EVENT_FLAG);
		chk(pll_irq_enable, plc_pkg::RST_PLL_IRQ_ENABLE);
		chk(auto_bw, plc_pkg::RST_AUTO_BW);
		give_verdict;
	end
endmodule // plc_ctl_tb_top
